// ===== src/counter_array_two.v
// Counter, timebase, flags and 16-bit PWM outputs of the second array.
// Assumes SFR strobes and all inputs are synchronous to ref_clk, except
// external_count_input and ext_osc_in, which are synchronised here.
`timescale 1ns/1ps
`include "counter_array_two_consts.vh"
module counter_array_two (
  input  wire         ref_clk,
  input  wire         rst,
  input  wire [7:0]   sfr_page,
  input  wire [7:0]   sfr_addr,
  input  wire         sfr_wr,
  input  wire [7:0]   sfr_wdata,
  input  wire         sfr_rd,
  input  wire         sfr_bit_wr,
  input  wire [2:0]   sfr_bit_sel,
  input  wire         sfr_bit_val,
  input  wire         cpu_idle,
  input  wire         timer0_overflow,
  input  wire         timer4_overflow,
  input  wire         timer5_overflow,
  input  wire         external_count_input,
  input  wire         ext_osc_in,
  input  wire [5:0]   comparator_enable,
  input  wire [5:0]   pwm16_enable,
  input  wire [5:0]   match_flag_enable,
  input  wire [5:0]   module_irq_enable,
  input  wire [5:0]   capture_event,
  input  wire [95:0]  module_compare_value,
  output reg  [7:0]   sfr_rdata,
  output reg  [15:0]  count_value,
  output reg  [5:0]   module_output_pin,
  output reg          irq_request
);
  reg  [7:0]  counter_array_control;
  reg  [7:0]  counter_array_mode;
  reg  [3:0]  div12_cnt;
  reg  [1:0]  div4_cnt;
  reg  [2:0]  osc_div_cnt;
  reg         eci_meta;
  reg         eci_sync;
  reg         eci_last;
  reg         osc_meta;
  reg         osc_sync;
  reg         osc_last;
  reg         tick_src;
  reg  [7:0]  next_control;
  reg  [5:0]  match_hit;
  reg  [5:0]  next_out;
  integer     i;

  // Page and address decode shared by both registers
  function sfr_hit;
    input [7:0] page;
    input [7:0] addr;
    input [7:0] target;
    begin
      sfr_hit = (page == `SFR_PAGE_ARRAY) && (addr == target);
    end
  endfunction

  wire        ctl_sel   = sfr_hit(sfr_page, sfr_addr, `ADDR_CONTROL);
  wire        mode_sel  = sfr_hit(sfr_page, sfr_addr, `ADDR_MODE);
  wire        mode_wr   = sfr_wr && mode_sel;
  wire        ctl_rd    = sfr_rd && ctl_sel;
  wire        mode_rd   = sfr_rd && mode_sel;
  wire [2:0]  timebase_select =
                counter_array_mode[`TB_HI:`TB_LO];
  wire        idle_suspend_bit = counter_array_mode[`BIT_IDLE_SUSP];
  wire        overflow_irq_enable = counter_array_mode[`BIT_IRQ_EN];
  wire        counter_run_bit = counter_array_control[`BIT_RUN];
  wire        counter_overflow_flag = counter_array_control[`BIT_OVERFLOW];
  // Suspension freezes prescalers too, so a resumed period is not cut short
  wire        suspended = cpu_idle & idle_suspend_bit;
  wire        div12_hit = (div12_cnt == `DIV12_LAST);
  wire        div4_hit  = (div4_cnt == `DIV4_LAST);
  wire        eci_fall  = eci_last & ~eci_sync;
  wire        osc_rise  = osc_sync & ~osc_last;
  wire        osc_hit   = osc_rise && (osc_div_cnt == `DIV8_LAST);
  wire        tick      = tick_src & counter_run_bit & ~suspended;
  wire        wrap      = tick && (count_value == `COUNT_MAX);
  wire [15:0] next_count = count_value + 16'h0001;
  // Request follows the flags as they stand after this edge
  wire        next_irq  =
                (next_control[`BIT_OVERFLOW] & overflow_irq_enable) |
                (|(next_control[5:0] & module_irq_enable));

  function [15:0] cmp_of;
    input [95:0] vals;
    input integer n;
    begin
      cmp_of = vals[n*16 +: 16];
    end
  endfunction

  // Timebase selection
  always @* begin
    case (timebase_select)
      `TB_DIV12:    tick_src = div12_hit;
      `TB_DIV4:     tick_src = div4_hit;
      `TB_TIMER0:   tick_src = timer0_overflow;
      `TB_EXT_EDGE: tick_src = eci_fall;
      `TB_SYSCLK:   tick_src = 1'b1;
      `TB_EXT_DIV8: tick_src = osc_hit;
      `TB_TIMER4:   tick_src = timer4_overflow;
      `TB_TIMER5:   tick_src = timer5_overflow;
      default:      tick_src = 1'b0;
    endcase
  end

  // Matches and PWM output levels
  always @* begin
    match_hit = 6'h00;
    next_out  = module_output_pin;
    for (i = 0; i < 6; i = i + 1) begin
      if (tick && (next_count == cmp_of(module_compare_value, i)))
        match_hit[i] = comparator_enable[i];
      // Match after a wrap to zero wins over the wrap, giving full high
      if (!comparator_enable[i] || !pwm16_enable[i])
        next_out[i] = 1'b0;
      else if (match_hit[i])
        next_out[i] = 1'b1;
      else if (wrap)
        next_out[i] = 1'b0;
    end
  end

  // Software write first, then hardware sets so a set is never lost
  always @* begin
    next_control = counter_array_control;
    if (sfr_wr && ctl_sel)
      next_control = sfr_wdata;
    else if (sfr_bit_wr && ctl_sel)
      next_control[sfr_bit_sel] = sfr_bit_val;
    if (wrap)
      next_control[`BIT_OVERFLOW] = 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      if ((match_hit[i] & match_flag_enable[i]) | capture_event[i])
        next_control[i] = 1'b1;
    end
  end

  // Two-stage synchronisers; edges are taken only between settled stages
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      eci_meta <= 1'b1;
      eci_sync <= 1'b1;
      eci_last <= 1'b1;
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_last <= 1'b0;
    end else begin
      eci_meta <= external_count_input;
      // Only the second and last stages are read by anything else
      eci_sync <= eci_meta;
      eci_last <= eci_sync;
      osc_meta <= ext_osc_in;
      osc_sync <= osc_meta;
      osc_last <= osc_sync;
    end
  end

  // Prescalers run free but hold their phase while suspended
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div12_cnt   <= 4'h0;
      div4_cnt    <= 2'h0;
      osc_div_cnt <= 3'h0;
    end else if (!suspended) begin
      div12_cnt <= div12_hit ? 4'h0 : div12_cnt + 4'h1;
      div4_cnt  <= div4_cnt + 2'h1;
      if (osc_rise)
        osc_div_cnt <= osc_div_cnt + 3'h1;
    end
  end

  // Wrap needs no special case; the adder rolls over to zero
  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      count_value <= `COUNT_ZERO;
    else if (tick)
      count_value <= next_count;
  end

  // Mode write masks the unused bits so they always read back as zero
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      counter_array_control <= `CONTROL_RESET;
      counter_array_mode    <= `MODE_RESET;
    end else begin
      counter_array_control <= next_control;
      if (mode_wr)
        counter_array_mode <= sfr_wdata & `MODE_WR_MASK;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      module_output_pin <= 6'h00;
      irq_request       <= 1'b0;
    end else begin
      module_output_pin <= next_out;
      irq_request       <= next_irq;
    end
  end

  // Read data holds between reads; unmapped reads return zero
  always @(posedge ref_clk or posedge rst) begin
    if (rst)
      sfr_rdata <= 8'h00;
    else if (ctl_rd)
      sfr_rdata <= counter_array_control;
    else if (mode_rd)
      sfr_rdata <= counter_array_mode;
    else if (sfr_rd)
      sfr_rdata <= 8'h00;
  end
endmodule

// ===== src/counter_array_two_consts.vh
// Constants for the second counter array control and status block.
// Assumes an SFR bus on one clock, with pages, byte and bit writes.
//
// Overview of operation
// - In 16-bit PWM a compare value of zero keeps the output high, and 0xffff gives one counter clock high in 65536.
// - A module with its comparator enable low never drives its PWM output high.
// - The overflow flag in control bit 7 is set when the counter wraps from 0xffff to 0 and stays set until software clears it.
// - Mode bit 0 set lets a set overflow flag request the interrupt; clear, it requests none.
// - Control bit 6 stops the counter when 0 and lets it advance on each selected timebase event when 1.
// - Modules 6 to 11 each have a control flag that hardware sets on match or capture, never clears, and that may request the interrupt.
// - Mode bit 7 at 0 keeps the array running in CPU idle, at 1 suspends it during idle.
// - Timebase code 000 is system clock / 12, 001 is system clock / 4, 100 is the system clock.
// - Timebase code 010 counts Timer 0 overflows, 110 Timer 4 overflows, 111 Timer 5 overflows.
// - Timebase code 011 counts falling edges of the external count input, which is kept at or below system clock / 4.
// - Timebase code 101 counts the external oscillator divided by 8, synchronised to the system clock.
// - Mode bits 6 to 4 read as zero and ignore writes.
// - The control register is bit-addressable on SFR page 0x10.
// - In 16-bit PWM the output goes high on a compare match and low on counter overflow.
`ifndef COUNTER_ARRAY_TWO_CONSTS_VH
`define COUNTER_ARRAY_TWO_CONSTS_VH
`define SFR_PAGE_ARRAY   8'h10
`define ADDR_CONTROL     8'hd8
`define ADDR_MODE        8'hd9
`define CONTROL_RESET    8'h00
`define MODE_RESET       8'h00
`define BIT_OVERFLOW     3'd7
`define BIT_RUN          3'd6
`define BIT_IDLE_SUSP    7
`define BIT_IRQ_EN       0
`define TB_HI            3
`define TB_LO            1
`define MODE_WR_MASK     8'h8f
`define TB_DIV12         3'b000
`define TB_DIV4          3'b001
`define TB_TIMER0        3'b010
`define TB_EXT_EDGE      3'b011
`define TB_SYSCLK        3'b100
`define TB_EXT_DIV8      3'b101
`define TB_TIMER4        3'b110
`define TB_TIMER5        3'b111
`define DIV12_LAST       4'hb
`define DIV4_LAST        2'h3
`define DIV8_LAST        3'h7
`define COUNT_MAX        16'hffff
`define COUNT_ZERO       16'h0000
`endif

// ===== sim/counter_array_two_chk.sv
// Port-level checker for the second counter array block.
// Assumes bind into counter_array_two, one clock, async high reset.
`timescale 1ns/1ps
module counter_array_two_chk (
  input wire        ref_clk,
  input wire        rst,
  input wire [7:0]  sfr_page,
  input wire [7:0]  sfr_addr,
  input wire        sfr_wr,
  input wire        sfr_rd,
  input wire        sfr_bit_wr,
  input wire [5:0]  comparator_enable,
  input wire [5:0]  pwm16_enable,
  input wire [5:0]  module_irq_enable,
  input wire [5:0]  capture_event,
  input wire [95:0] module_compare_value,
  input wire [7:0]  sfr_rdata,
  input wire [15:0] count_value,
  input wire [5:0]  module_output_pin,
  input wire        irq_request
);
  wire [15:0] cmp0 = module_compare_value[15:0];
  wire        en0  = comparator_enable[0] & pwm16_enable[0];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_step;
    count_value != $past(count_value);
  endsequence
  sequence s_wrap;
    $past(count_value) == 16'hffff ##0 count_value == 16'h0000;
  endsequence
  property p_off;
    (module_output_pin & ~$past(comparator_enable)) == 6'h00;
  endproperty
  property p_step;
    s_step |-> count_value == $past(count_value) + 16'h0001;
  endproperty
  property p_rise;
    $past(en0) ##0 s_step ##0 count_value == $past(cmp0)
      |-> module_output_pin[0];
  endproperty
  property p_fall;
    $past(en0) ##0 s_wrap ##0 $past(cmp0) != 16'h0000
      |-> !module_output_pin[0];
  endproperty
  property p_cap;
    |(capture_event & module_irq_enable) |=> irq_request;
  endproperty
  property p_hold;
    irq_request && !sfr_wr && !sfr_bit_wr |=> irq_request;
  endproperty
  property p_mode;
    sfr_rd && sfr_page == 8'h10 && sfr_addr == 8'hd9
      |=> sfr_rdata[6:4] == 3'h0;
  endproperty
  property p_unmap;
    sfr_rd && sfr_page == 8'h10 && sfr_addr == 8'hda |=> sfr_rdata == 8'h00;
  endproperty
  a_off: assert property (p_off) else $error("pin high while disabled");
  a_step: assert property (p_step) else $error("count jumped");
  a_rise: assert property (p_rise) else $error("no rise on match");
  a_fall: assert property (p_fall) else $error("no fall on wrap");
  a_cap: assert property (p_cap) else $error("capture gave no irq");
  a_hold: assert property (p_hold) else $error("flag self cleared");
  a_mode: assert property (p_mode) else $error("unused mode bits");
  a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule
bind counter_array_two counter_array_two_chk u_chk (.*);

// ===== sim/tb.sv
// Self-checking bench for counter_array_two over its SFR strobes.
// Assumes the design files compile first; ref_clk is 10 MHz.
`timescale 1ns/1ps
module tb;
  logic        ref_clk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, sfr_bit_wr = 0;
  logic        sfr_bit_val = 0, cpu_idle = 0, timer0_overflow = 0;
  logic        timer4_overflow = 0, timer5_overflow = 0, ext_osc_in = 0;
  logic        external_count_input = 0, irq_request;
  logic [7:0]  sfr_page = 8'h10, sfr_addr = 8'h00, sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata;
  logic [2:0]  sfr_bit_sel = 3'h0;
  logic [5:0]  comparator_enable = 6'h03, pwm16_enable = 6'h03;
  logic [5:0]  match_flag_enable = 6'h00, module_irq_enable = 6'h01;
  logic [5:0]  capture_event = 6'h00, module_output_pin;
  logic [95:0] module_compare_value = 96'h8000;
  logic [15:0] count_value, c0;
  int          err_count = 0, comparisons = 0, cyc = 0;
  // Every source period divides 96, so prescaler phase cannot skew a count
  int          rate [8] = '{8, 24, 48, 12, 96, 3, 32, 24};
  counter_array_two dut (.*);
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    timer0_overflow <= (cyc % 2 == 0);
    timer4_overflow <= (cyc % 3 == 0);
    timer5_overflow <= (cyc % 4 == 0);
    external_count_input <= cyc[2];
    ext_osc_in <= cyc[1];
  end
  task chk(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'h1;
    @(posedge ref_clk);
    sfr_wr <= 1'h0;
  endtask
  task bw(input logic [2:0] s, input logic v);
    @(posedge ref_clk);
    sfr_addr <= 8'hd8;
    sfr_bit_sel <= s;
    sfr_bit_val <= v;
    sfr_bit_wr <= 1'h1;
    @(posedge ref_clk);
    sfr_bit_wr <= 1'h0;
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'h1;
    @(posedge ref_clk);
    sfr_rd <= 1'h0;
    @(negedge ref_clk);
    chk({8'h00, sfr_rdata}, {8'h00, e});
  endtask
  task delta(input int n, e);
    repeat (8) @(posedge ref_clk);
    c0 = count_value;
    repeat (n) @(posedge ref_clk);
    chk(count_value - c0, e[15:0]);
  endtask
  task final_report;
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #8000000;
    err_count++;
    final_report;
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'h0;
    rd(8'hd8, 8'h00);
    rd(8'hd9, 8'h00);
    wr(8'hd9, 8'hff);
    rd(8'hd9, 8'h8f);
    rd(8'hda, 8'h00);
    @(posedge ref_clk);
    sfr_page <= 8'h0f;
    rd(8'hd9, 8'h00);
    @(posedge ref_clk);
    sfr_page <= 8'h10;
    wr(8'hd9, 8'h09);
    bw(3'h6, 1'h1);
    for (int i = 0; i < 70000 && count_value !== 16'hffff; i++)
      @(negedge ref_clk);
    chk(module_output_pin[0], 1'h1);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(module_output_pin, 6'h02);
    chk(irq_request, 1'h1);
    rd(8'hd8, 8'hc0);
    bw(3'h7, 1'h0);
    rd(8'hd8, 8'h40);
    chk(irq_request, 1'h0);
    @(posedge ref_clk);
    capture_event <= 6'h01;
    @(posedge ref_clk);
    capture_event <= 6'h00;
    rd(8'hd8, 8'h41);
    chk(irq_request, 1'h1);
    wr(8'hd8, 8'h40);
    for (int k = 0; k < 8; k++) begin
      wr(8'hd9, {4'h0, k[2:0], 1'h0});
      delta(96, rate[k]);
    end
    wr(8'hd9, 8'h88);
    cpu_idle <= 1'h1;
    delta(40, 0);
    wr(8'hd9, 8'h08);
    delta(40, 40);
    bw(3'h6, 1'h0);
    delta(40, 0);
    final_report;
  end
endmodule
